// >>> rtl/fp_register_file.sv
// floating-point register array, single words or double pairs
// assumes the writer gives an even index for a double access
`timescale 1ns/1ns
module fp_register_file #(
   parameter int NUM_REGS = 32
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // write port
   input  wire logic        wr_en,
   input  wire logic        wr_double,
   input  wire logic [4:0]  wr_idx,
   input  wire logic [63:0] wr_data,
   // read port
   input  wire logic [4:0]  rd_idx,
   input  wire logic        rd_double,
   output logic      [63:0] rd_data
);

   logic [31:0] mem [NUM_REGS];
   logic [63:0] rd_data_reg;

   // =====================================================
   // write: a double pair is the even word (high half) and the odd one
   always_ff @(posedge clk) begin
      if (wr_en) begin
         if (wr_double) begin
            mem[{wr_idx[4:1], 1'b0}] <= wr_data[63:32];
            mem[{wr_idx[4:1], 1'b1}] <= wr_data[31:0];
         end else begin
            mem[wr_idx] <= wr_data[31:0];
         end
      end
   end

   // =====================================================
   // registered read, single in the low half
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_data_reg <= 64'h0000000000000000;
      end else if (rd_double) begin
         rd_data_reg <= {mem[{rd_idx[4:1], 1'b0}], mem[{rd_idx[4:1], 1'b1}]};
      end else begin
         rd_data_reg <= {32'h00000000, mem[rd_idx]};
      end
   end

   assign rd_data = rd_data_reg;

endmodule

// >>> rtl/fpu_exc_map.svh
// constants of the floating-point exception and flag block
// assumes one core clock and a synchronous active-high reset
`ifndef FPU_EXC_MAP_SVH
`define FPU_EXC_MAP_SVH

// =====================================================
// status/control word layout
`define FPX_RM_BIT        0
`define FPX_FLAG_LO       2
`define FPX_EN_LO         7
`define FPX_CAUSE_LO      12
`define FPX_DN_BIT        18
`define FPX_FP_STATUS_CONTROL_REG_MASK    32'h0007FFFD
`define FPX_FP_STATUS_CONTROL_REG_RESET   32'h00000000

// =====================================================
// source positions inside cause, flag and enable; the error one only inside cause
`define FPX_SRC_I         0
`define FPX_SRC_U         1
`define FPX_SRC_O         2
`define FPX_SRC_Z         3
`define FPX_SRC_V         4
`define FPX_SRC_E         5

// =====================================================
// operand layouts
`define FPX_S_SIGN        31
`define FPX_S_EXP_HI      30
`define FPX_S_EXP_LO      23
`define FPX_S_FRAC_HI     22
`define FPX_D_SIGN        63
`define FPX_D_EXP_HI      62
`define FPX_D_EXP_LO      52
`define FPX_D_FRAC_HI     51

// =====================================================
// default results
`define FPX_S_QNAN        32'h7FC00000
`define FPX_D_QNAN        64'h7FF8000000000000
`define FPX_S_INF         32'h7F800000
`define FPX_D_INF         64'h7FF0000000000000
`define FPX_S_INF_BODY    31'h7F800000
`define FPX_D_INF_BODY    63'h7FF0000000000000

`endif

// >>> rtl/fpu_exc_pkg.sv
// types of the floating-point exception and flag block
// assumes the constants header is included by users
package fpu_exc_pkg;

   // =====================================================
   // modes
   typedef enum logic {
      RND_NEAREST = 1'b0,
      RND_ZERO    = 1'b1
   } round_mode_e;

   typedef enum logic {
      DNM_FULL  = 1'b0,
      DNM_FLUSH = 1'b1
   } denorm_mode_e;

   typedef logic [5:0] cause_t;
   typedef logic [4:0] flag_t;

endpackage

// >>> rtl/fpu_exception_flags.sv
// exception detection, sticky flags and trap decision of the fpu
// assumes issue and datapath inputs come from logic on the same clock
`timescale 1ns/1ns
`include "fpu_exc_map.svh"
module fpu_exception_flags (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // cpu status word
   input  wire logic        fpu_disable_bit,
   // status/control word access
   input  wire logic        fp_status_control_reg_wr_en,
   input  wire logic [31:0] fp_status_control_reg_wdata,
   output logic      [31:0] fp_status_control_reg_rdata,
   // modes towards the datapath
   output logic             round_to_zero,
   output logic             flush_to_zero,
   // instruction issue
   input  wire logic        instr_valid,
   input  wire logic        instr_is_fp,
   input  wire logic        vector_transform_instr,
   input  wire logic        instr_double,
   input  wire logic [4:0]  dest_idx,
   input  wire logic [63:0] op_a,
   input  wire logic [63:0] op_b,
   // datapath sources
   input  wire logic        src_invalid,
   input  wire logic        src_div_zero,
   input  wire logic        src_overflow,
   input  wire logic        src_underflow,
   input  wire logic        src_inexact,
   input  wire logic        may_overflow,
   input  wire logic        may_underflow,
   input  wire logic        may_inexact,
   input  wire logic        unrounded_sign,
   input  wire logic [63:0] dp_result,
   // register load path
   input  wire logic        ld_wr_en,
   input  wire logic        ld_double,
   input  wire logic [4:0]  ld_idx,
   input  wire logic [63:0] ld_data,
   // register read port
   input  wire logic [4:0]  rd_idx,
   input  wire logic        rd_double,
   output logic      [63:0] rd_data,
   // events
   output logic             fpu_disable_exc,
   output logic             fpu_exc,
   output logic             instr_done
);

   // =====================================================
   // operand classification
   function automatic logic is_denormal(input logic [63:0] op, input logic dbl);
      logic den;
      den = 1'b0;
      if (dbl) begin
         den = (op[`FPX_D_EXP_HI:`FPX_D_EXP_LO] == 11'h000) &&
               (op[`FPX_D_FRAC_HI:0] != 52'h0000000000000);
      end else begin
         den = (op[`FPX_S_EXP_HI:`FPX_S_EXP_LO] == 8'h00) &&
               (op[`FPX_S_FRAC_HI:0] != 23'h000000);
      end
      return den;
   endfunction

   // =====================================================
   // state
   logic [31:0]            fp_status_control_reg_reg;
   logic [31:0]            fp_status_control_reg_next;
   logic                   disable_exc_reg;
   logic                   trap_reg;
   logic                   done_reg;
   logic                   exec;
   logic                   denorm_in;
   fpu_exc_pkg::cause_t    src_vec;
   fpu_exc_pkg::flag_t     trap_vec;
   fpu_exc_pkg::flag_t     enables;
   fpu_exc_pkg::flag_t     flags_base;
   logic                   trap_now;
   logic                   dn_bit;
   logic                   res_wr_en;
   logic [63:0]            res_data;
   logic                   rf_wr_en;
   logic                   rf_wr_double;
   logic [4:0]             rf_wr_idx;
   logic [63:0]            rf_wr_data;

   assign dn_bit  = fp_status_control_reg_reg[`FPX_DN_BIT];
   assign enables = fp_status_control_reg_reg[`FPX_EN_LO +: 5];

   // a disabled fpu never reaches the trap or write logic
   assign exec = instr_valid && instr_is_fp && !fpu_disable_bit;

   assign denorm_in = is_denormal(op_a, instr_double) || is_denormal(op_b, instr_double);

   // =====================================================
   // sources of this instruction
   always_comb begin
      src_vec                = 6'h00;
      src_vec[`FPX_SRC_E]    = denorm_in && !dn_bit;
      src_vec[`FPX_SRC_V]    = src_invalid;
      src_vec[`FPX_SRC_Z]    = src_div_zero;
      src_vec[`FPX_SRC_O]    = src_overflow;
      src_vec[`FPX_SRC_U]    = src_underflow;
      src_vec[`FPX_SRC_I]    = src_inexact;
   end

   // =====================================================
   // trap decision; possibility, not occurrence, drives o/u/i
   always_comb begin
      trap_vec             = 5'h00;
      trap_vec[`FPX_SRC_V] = enables[`FPX_SRC_V] &&
                             (vector_transform_instr || src_invalid);
      trap_vec[`FPX_SRC_Z] = enables[`FPX_SRC_Z] && src_div_zero;
      trap_vec[`FPX_SRC_O] = enables[`FPX_SRC_O] && may_overflow;
      trap_vec[`FPX_SRC_U] = enables[`FPX_SRC_U] && may_underflow;
      trap_vec[`FPX_SRC_I] = enables[`FPX_SRC_I] && may_inexact;
   end

   // error source has no enable bit, so it always traps
   assign trap_now = src_vec[`FPX_SRC_E] || (trap_vec != 5'h00);

   // =====================================================
   // default result for untrapped cases
   always_comb begin
      res_data = dp_result;
      if (src_invalid) begin
         res_data = instr_double ? `FPX_D_QNAN : {32'h00000000, `FPX_S_QNAN};
      end else if (src_div_zero) begin
         if (instr_double) begin
            res_data = {unrounded_sign, `FPX_D_INF_BODY};
         end else begin
            res_data = {32'h00000000, unrounded_sign, `FPX_S_INF_BODY};
         end
      end
   end

   // destination untouched on a trap
   assign res_wr_en = exec && !trap_now;

   // =====================================================
   // register file write mux, instruction result wins over a load
   always_comb begin
      rf_wr_en     = res_wr_en || ld_wr_en;
      rf_wr_double = ld_double;
      rf_wr_idx    = ld_idx;
      rf_wr_data   = ld_data;
      if (res_wr_en) begin
         rf_wr_double = instr_double;
         rf_wr_idx    = dest_idx;
         rf_wr_data   = res_data;
      end
   end

   fp_register_file #(
      .NUM_REGS (32)
   ) u_regs (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .wr_en     (rf_wr_en),
      .wr_double (rf_wr_double),
      .wr_idx    (rf_wr_idx),
      .wr_data   (rf_wr_data),
      .rd_idx    (rd_idx),
      .rd_double (rd_double),
      .rd_data   (rd_data)
   );

   // =====================================================
   // status/control word next value
   // a software write and a flag set in one cycle: the set wins
   always_comb begin
      fp_status_control_reg_next = fp_status_control_reg_reg;
      if (fp_status_control_reg_wr_en) begin
         fp_status_control_reg_next = fp_status_control_reg_wdata & `FPX_FP_STATUS_CONTROL_REG_MASK;
      end
      flags_base = fp_status_control_reg_next[`FPX_FLAG_LO +: 5];
      if (exec) begin
         fp_status_control_reg_next[`FPX_CAUSE_LO +: 6] = src_vec;
         fp_status_control_reg_next[`FPX_FLAG_LO +: 5]  = flags_base | src_vec[4:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fp_status_control_reg_reg <= `FPX_FP_STATUS_CONTROL_REG_RESET;
      end else begin
         fp_status_control_reg_reg <= fp_status_control_reg_next;
      end
   end

   // =====================================================
   // event pulses, one cycle after issue
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         disable_exc_reg <= 1'b0;
      end else begin
         disable_exc_reg <= instr_valid && instr_is_fp && fpu_disable_bit;
      end
   end

   // one common trap event; the cause field shows occurred sources, not an o/u/i possibility or a transform that trapped
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trap_reg <= 1'b0;
      end else begin
         trap_reg <= exec && trap_now;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= res_wr_en;
      end
   end

   assign fp_status_control_reg_rdata     = fp_status_control_reg_reg;
   assign round_to_zero   = fp_status_control_reg_reg[`FPX_RM_BIT] == fpu_exc_pkg::RND_ZERO;
   assign flush_to_zero   = dn_bit == fpu_exc_pkg::DNM_FLUSH;
   assign fpu_disable_exc = disable_exc_reg;
   assign fpu_exc         = trap_reg;
   assign instr_done      = done_reg;

   // =====================================================
   // assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   property p_disable;
      instr_valid && instr_is_fp && fpu_disable_bit && !fp_status_control_reg_wr_en
         |=> fpu_disable_exc && !fpu_exc && !instr_done && $stable(fp_status_control_reg_rdata);
   endproperty
   a_disable: assert property (p_disable) else $error("disabled fpu executed");

   property p_cause;
      exec |=> fp_status_control_reg_rdata[`FPX_CAUSE_LO +: 6] == $past(src_vec);
   endproperty
   a_cause: assert property (p_cause) else $error("cause field wrong");

   property p_flag;
      exec && !fp_status_control_reg_wr_en |=> fp_status_control_reg_rdata[`FPX_FLAG_LO +: 5] ==
         ($past(fp_status_control_reg_rdata[`FPX_FLAG_LO +: 5]) | $past(src_vec[4:0]));
   endproperty
   a_flag: assert property (p_flag) else $error("sticky flag wrong");

   property p_err_trap;
      exec && !dn_bit && denorm_in |=> fpu_exc && !instr_done;
   endproperty
   a_err_trap: assert property (p_err_trap) else $error("error trap missed");

   property p_inv_trap;
      exec && enables[`FPX_SRC_V] && (vector_transform_instr || src_invalid) |=> fpu_exc;
   endproperty
   a_inv_trap: assert property (p_inv_trap) else $error("invalid trap missed");

   property p_dz_trap;
      exec && enables[`FPX_SRC_Z] && src_div_zero |=> fpu_exc;
   endproperty
   a_dz_trap: assert property (p_dz_trap) else $error("divide trap missed");

   property p_ovf_trap;
      exec && enables[`FPX_SRC_O] && may_overflow && !src_overflow |=> fpu_exc;
   endproperty
   a_ovf_trap: assert property (p_ovf_trap) else $error("overflow trap missed");

   property p_no_write;
      exec && trap_now |-> !(rf_wr_en && rf_wr_idx == dest_idx && !ld_wr_en);
   endproperty
   a_no_write: assert property (p_no_write) else $error("trap wrote destination");

   property p_qnan;
      exec && !trap_now && src_invalid && !instr_double
         |-> rf_wr_en && rf_wr_data[31:0] == `FPX_S_QNAN;
   endproperty
   a_qnan: assert property (p_qnan) else $error("no quiet nan");

   property p_inf;
      exec && !trap_now && src_div_zero && !src_invalid && instr_double
         |-> rf_wr_data[`FPX_D_SIGN] == unrounded_sign &&
             rf_wr_data[`FPX_D_EXP_HI:`FPX_D_EXP_LO] == 11'h7FF;
   endproperty
   a_inf: assert property (p_inf) else $error("infinity wrong");

   property p_done;
      exec && !trap_now |=> instr_done && !fpu_exc ##1 !instr_done || $past(exec);
   endproperty
   a_done: assert property (p_done) else $error("untrapped not completed");

   property p_one_event;
      !(fpu_exc && fpu_disable_exc) && !(fpu_exc && instr_done);
   endproperty
   a_one_event: assert property (p_one_event) else $error("events overlap");

   property p_reserved;
      fp_status_control_reg_rdata[31:19] == 13'h0000 && fp_status_control_reg_rdata[1] == 1'b0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");

   property p_unf_trap;
      exec && enables[`FPX_SRC_U] && may_underflow && !src_underflow |=> fpu_exc;
   endproperty
   a_unf_trap: assert property (p_unf_trap) else $error("underflow trap missed");

   property p_inx_trap;
      exec && enables[`FPX_SRC_I] && may_inexact && !src_inexact |=> fpu_exc;
   endproperty
   a_inx_trap: assert property (p_inx_trap) else $error("inexact trap missed");

   property p_vt_trap;
      exec && enables[`FPX_SRC_V] && vector_transform_instr && !src_invalid |=> fpu_exc;
   endproperty
   a_vt_trap: assert property (p_vt_trap) else $error("transform trap missed");

   property p_err_cause;
      exec && !dn_bit && denorm_in |=> fp_status_control_reg_rdata[`FPX_CAUSE_LO + `FPX_SRC_E];
   endproperty
   a_err_cause: assert property (p_err_cause) else $error("error cause missing");

   property p_qnan_dbl;
      exec && !trap_now && src_invalid && instr_double
         |-> rf_wr_en && rf_wr_data == `FPX_D_QNAN;
   endproperty
   a_qnan_dbl: assert property (p_qnan_dbl) else $error("no double quiet nan");

   property p_default;
      exec && !trap_now && !src_invalid && !src_div_zero
         |-> rf_wr_en && rf_wr_double == instr_double && rf_wr_data == dp_result;
   endproperty
   a_default: assert property (p_default) else $error("result not written");

   property p_inf_sgl;
      exec && !trap_now && src_div_zero && !src_invalid && !instr_double
         |-> rf_wr_data[`FPX_S_SIGN] == unrounded_sign &&
             rf_wr_data[`FPX_S_EXP_HI:`FPX_S_EXP_LO] == 8'hFF &&
             rf_wr_data[`FPX_S_FRAC_HI:0] == 23'h000000;
   endproperty
   a_inf_sgl: assert property (p_inf_sgl) else $error("single infinity wrong");

   c_disable: cover property (instr_valid && instr_is_fp && fpu_disable_bit ##1 fpu_disable_exc);
   c_trap:    cover property (exec && trap_now ##1 fpu_exc);
   c_qnan:    cover property (exec && !trap_now && src_invalid ##1 instr_done);
   c_wr_set:  cover property (exec && fp_status_control_reg_wr_en && (src_vec[4:0] != 5'h00));
   c_err:     cover property (exec && src_vec[`FPX_SRC_E] ##1 fpu_exc);

endmodule

// >>> testbench/fp_datapath_model.sv
// behavioural arithmetic datapath: operands and kind in, sources and result out
// assumes single operands sit in the low 32 bits, combinational in the issue cycle
`timescale 1ns/1ns
module fp_datapath_model (
   // operation
   input  wire logic        div_op,
   input  wire logic        arith_op,
   input  wire logic        instr_double,
   input  wire logic [63:0] op_a,
   input  wire logic [63:0] op_b,
   // sources and result
   output logic             src_invalid,
   output logic             src_div_zero,
   output logic             src_overflow,
   output logic             src_underflow,
   output logic             src_inexact,
   output logic             may_overflow,
   output logic             may_underflow,
   output logic             may_inexact,
   output logic             unrounded_sign,
   output logic [63:0]      dp_result
);
   logic [10:0] ea;
   logic [10:0] eb;
   logic [10:0] top;
   logic        zb;
   // =====================================================
   // field split and crude source detection
   always_comb begin
      ea = instr_double ? op_a[62:52] : {3'h0, op_a[30:23]};
      eb = instr_double ? op_b[62:52] : {3'h0, op_b[30:23]};
      top = instr_double ? 11'h7FF : 11'h0FF;
      zb = instr_double ? (op_b[62:0] == 63'h0) : (op_b[30:0] == 31'h0);
      src_invalid = arith_op & ((ea == top) | (eb == top));
      src_div_zero = arith_op & div_op & zb & !src_invalid;
      src_overflow = arith_op & !src_invalid & ea[7] & eb[7];
      src_underflow = arith_op & !src_invalid & (ea < 11'h004) & !zb;
      src_inexact = src_overflow | src_underflow | (arith_op & (op_a[0] ^ op_b[0]));
      // possibility is coarse: any arithmetic kind may yield all three
      may_overflow = arith_op;
      may_underflow = arith_op;
      may_inexact = arith_op;
      unrounded_sign = instr_double ? op_a[63] ^ op_b[63] : op_a[31] ^ op_b[31];
      dp_result = op_a ^ {op_b[31:0], op_b[63:32]};
   end
endmodule

// >>> testbench/fpu_exception_flags_tb_top.sv
// random instruction bench for the fpu exception and flag block
// assumes the datapath model feeds the sources; inputs change at falling edges
`timescale 1ns/1ns
`include "fpu_exc_map.svh"
module fpu_exception_flags_tb_top;
   // =====================================================
   // signals
   logic        clk, sys_rst, fpu_disable_bit, fp_status_control_reg_wr_en, instr_valid, instr_is_fp;
   logic        vector_transform_instr, instr_double, ld_wr_en, ld_double, rd_double;
   logic        div_op, arith_op, round_to_zero, flush_to_zero;
   logic        fpu_disable_exc, fpu_exc, instr_done, d;
   logic        src_invalid, src_div_zero, src_overflow, src_underflow, src_inexact;
   logic        may_overflow, may_underflow, may_inexact, unrounded_sign;
   logic [31:0] fp_status_control_reg_wdata, fp_status_control_reg_rdata, fx;
   logic [63:0] op_a, op_b, ld_data, rd_data, dp_result;
   logic [4:0]  dest_idx, ld_idx, rd_idx, i;
   logic [31:0] sh [32];
   int          error_cnt, compares, seed;

   always #50 clk = ~clk;

   fpu_exception_flags u_dut (
      .clk, .sys_rst, .fpu_disable_bit, .fp_status_control_reg_wr_en, .fp_status_control_reg_wdata, .fp_status_control_reg_rdata,
      .round_to_zero, .flush_to_zero, .instr_valid, .instr_is_fp, .vector_transform_instr,
      .instr_double, .dest_idx, .op_a, .op_b, .src_invalid, .src_div_zero, .src_overflow,
      .src_underflow, .src_inexact, .may_overflow, .may_underflow, .may_inexact,
      .unrounded_sign, .dp_result, .ld_wr_en, .ld_double, .ld_idx, .ld_data, .rd_idx,
      .rd_double, .rd_data, .fpu_disable_exc, .fpu_exc, .instr_done
   );
   fp_datapath_model u_dp (
      .div_op, .arith_op, .instr_double, .op_a, .op_b, .src_invalid, .src_div_zero,
      .src_overflow, .src_underflow, .src_inexact, .may_overflow, .may_underflow,
      .may_inexact, .unrounded_sign, .dp_result
   );

   // =====================================================
   // helpers
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   function automatic logic den(input logic dd, input logic [63:0] v);
      den = dd ? (v[62:52] == 11'h0 && v[51:0] != 52'h0) : (v[30:23] == 8'h0 && v[22:0] != 23'h0);
   endfunction

   // skewed operand mix: denormals, zeros and all-ones exponents are the awkward ones
   function automatic logic [63:0] mk(input logic dd);
      logic [63:0] v;
      v = {$urandom, $urandom};
      case ($urandom % 6)
         0: v = dd ? {v[63], 11'h000, v[51:0]} : {32'h0, v[31], 8'h00, v[22:0]};
         1: v = 64'h0;
         2: v = dd ? {v[63], 11'h7FF, v[51:0]} : {32'h0, v[31], 8'hFF, v[22:0]};
         default: v = dd ? v : {32'h0, v[31:0]};
      endcase
      mk = v;
   endfunction

   task automatic wr(input logic [31:0] v);
      fp_status_control_reg_wr_en = 1'b1;
      fp_status_control_reg_wdata = v;
      instr_valid = 1'b0;
      @(negedge clk);
      fx = v & `FPX_FP_STATUS_CONTROL_REG_MASK;
      chk("fp_status_control_reg_wr", {32'h0, fx}, {32'h0, fp_status_control_reg_rdata});
      chk("modes", {62'h0, fx[18], fx[0]}, {62'h0, flush_to_zero, round_to_zero});
   endtask

   // strobes stay up between back-to-back calls; the next kind of task lowers them
   task automatic ld(input logic [4:0] k, input logic dd, input logic [63:0] v);
      fp_status_control_reg_wr_en = 1'b0;
      ld_wr_en = 1'b1;
      ld_double = dd;
      ld_idx = k;
      ld_data = v;
      @(negedge clk);
      if (dd) begin
         sh[k] = v[63:32];
         sh[k + 5'd1] = v[31:0];
      end else begin
         sh[k] = v[31:0];
      end
   endtask

   task automatic rd(input logic [4:0] k, input logic dd);
      rd_idx = k;
      rd_double = dd;
      ld_wr_en = 1'b0;
      instr_valid = 1'b0;
      @(negedge clk);
      chk("pulses", 64'h0, {62'h0, fpu_exc, instr_done});
      if (dd) chk("rd_dbl", {sh[k], sh[k + 5'd1]}, rd_data);
      else chk("rd_sgl", {32'h0, sh[k]}, {32'h0, rd_data[31:0]});
   endtask

   task automatic ins(input logic fp, vt, dv, ar, dd, dis, input logic [4:0] k);
      logic [5:0]  src;
      logic [63:0] r;
      logic        e;
      logic        tr;
      logic        ex;
      fpu_disable_bit = dis;
      instr_valid = 1'b1;
      instr_is_fp = fp;
      vector_transform_instr = vt;
      div_op = dv;
      arith_op = ar;
      instr_double = dd;
      dest_idx = k;
      op_a = mk(dd);
      op_b = mk(dd);
      #1;
      ex = fp & !dis;
      e = !fx[18] & (den(dd, op_a) | den(dd, op_b));
      src = {e, src_invalid, src_div_zero, src_overflow, src_underflow, src_inexact};
      tr = e | (fx[11] & (vt | src_invalid)) | (fx[10] & src_div_zero)
         | (fx[9] & may_overflow) | (fx[8] & may_underflow) | (fx[7] & may_inexact);
      if (fp_status_control_reg_wr_en) fx = fp_status_control_reg_wdata & `FPX_FP_STATUS_CONTROL_REG_MASK;
      r = dp_result;
      if (src_invalid) r = dd ? `FPX_D_QNAN : {32'h0, `FPX_S_QNAN};
      else if (src_div_zero && dd) r = {unrounded_sign, 63'h0} | `FPX_D_INF;
      else if (src_div_zero) r = {32'h0, unrounded_sign, 31'h0} | {32'h0, `FPX_S_INF};
      if (ex) begin
         fx[17:12] = src;
         fx[6:2] = fx[6:2] | src[4:0];
      end
      if (ex && !tr && dd) begin
         sh[k] = r[63:32];
         sh[k + 5'd1] = r[31:0];
      end else if (ex && !tr) begin
         sh[k] = r[31:0];
      end
      @(negedge clk);
      fp_status_control_reg_wr_en = 1'b0;
      chk("disable_exc", {63'h0, fp & dis}, {63'h0, fpu_disable_exc});
      chk("trap", {63'h0, ex & tr}, {63'h0, fpu_exc});
      chk("done", {63'h0, ex & !tr}, {63'h0, instr_done});
      chk("fp_status_control_reg_ex", {32'h0, fx}, {32'h0, fp_status_control_reg_rdata});
   endtask

   // =====================================================
   // sequence
   initial begin
      {clk, fpu_disable_bit, fp_status_control_reg_wr_en, instr_valid, instr_is_fp} = 5'h00;
      {vector_transform_instr, instr_double, ld_wr_en, ld_double, rd_double} = 5'h00;
      {div_op, arith_op, d} = 3'h0;
      sys_rst = 1'b1;
      {fp_status_control_reg_wdata, fx} = 64'h0;
      {op_a, op_b, ld_data} = 192'h0;
      {dest_idx, ld_idx, rd_idx, i} = 20'h0;
      error_cnt = 0;
      compares = 0;
      seed = 32'hC7F351D7;
      void'($urandom(seed));
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      chk("rst_fp_status_control_reg", 64'h0, {32'h0, fp_status_control_reg_rdata});
      chk("rst_pulses", 64'h0, {61'h0, fpu_disable_exc, fpu_exc, instr_done});
      chk("rst_rd", 64'h0, rd_data);
      wr(32'hFFFFFFFF);
      wr(32'h00000F80);
      for (int n = 0; n < 32; n++) ld(5'(n), 1'b0, {$urandom, $urandom});
      ld(5'd6, 1'b1, {$urandom, $urandom});
      for (int n = 0; n < 32; n += 2) rd(5'(n), 1'b1);
      ins(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 5'd4);
      rd(5'd4, 1'b0);
      repeat (400) begin
         if ($urandom % 4 == 0) wr($urandom);
         d = 1'($urandom % 2);
         i = 5'($urandom % 32) & ~{4'h0, d};
         repeat (($urandom % 3 == 0) ? 2 : 1)
            ins(1'($urandom % 8 != 0), 1'($urandom % 6 == 0), 1'($urandom % 3 == 0),
                1'($urandom % 5 != 0), d, 1'($urandom % 10 == 0), i);
         rd(i, d);
      end
      stop_test();
   end

   // hang guard
   initial begin
      #6000000;
      error_cnt++;
      stop_test();
   end
endmodule
